// file: core/usr_defines.svh
// register offsets, field positions, reset values and sample timing of the serial receiver
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH

`define USR_ADDR_DATA 3'h0
`define USR_ADDR_STAT_A 3'h1
`define USR_ADDR_CTRL_B 3'h2
`define USR_ADDR_CTRL_C 3'h3
`define USR_ADDR_BAUD 3'h4

`define USR_A_RXC 7
`define USR_A_FE 4
`define USR_A_DOR 3
`define USR_A_PE 2
`define USR_A_U2X 1

`define USR_B_RX_DONE_IRQ_ENABLE 7
`define USR_B_RECEIVER_ENABLE 4
`define USR_B_UCSZ2 2
`define USR_B_NINTH_BIT_RECEIVED 1

`define USR_C_SYNC 6
`define USR_C_PAR_EN 5
`define USR_C_PAR_ODD 4
`define USR_C_STOP2 3
`define USR_C_CHAR_SIZE_FIELD_LO 1

`define USR_E_NINTH 8
`define USR_E_PE 9
`define USR_E_DOR 10
`define USR_E_FE 11

`define USR_RST_BAUD 8'h00
`define USR_RST_CHAR_SIZE_FIELD 2'h3

`define USR_SPB_NORMAL 5'h10
`define USR_SPB_DOUBLE 5'h08
`define USR_VOTE_NORMAL 5'h08
`define USR_VOTE_DOUBLE 5'h04
`define USR_VOTE_SPAN 5'h02

`define USR_MIN_BITS 4'h5
`define USR_NINE_BITS 4'h9

`endif

// file: core/usr_pkg.sv
// types shared by the serial receiver modules
package usr_pkg;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} usr_fsm_t;

	// one receive buffer entry: fe, dor, pe, ninth bit, data byte
	typedef logic [11:0] usr_entry_t;

	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
	} usr_sync_state_t;

	typedef struct packed {
		usr_entry_t [1:0] mem;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] count;
	} usr_fifo_state_t;

	typedef struct packed {
		usr_fsm_t st;
		logic [4:0] cnt;
		logic [2:0] vote;
		logic [3:0] bitIdx;
		logic [8:0] shift;
		logic parErr;
		logic parEn;
		logic pend;
		usr_entry_t pendEntry;
		logic lost;
		logic [7:0] baudCnt;
		logic xckPrev;
		logic rxPrev;
		logic receiver_enable;
		logic rx_done_irq_enable;
		logic ucsz2;
		logic u2x;
		logic syncMode;
		logic parEnable;
		logic parOdd;
		logic stop2;
		logic [1:0] char_size_field;
		logic [7:0] baud;
		logic [7:0] rdata;
	} usr_rx_state_t;

endpackage : usr_pkg

// file: core/usr_sync.sv
// two-flop synchronisers for the serial data pin and the external transfer clock pin
`timescale 1ns/10ps
module usr_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] pinIn,
	output logic [1:0] pinSync
);
	usr_pkg::usr_sync_state_t r;
	usr_pkg::usr_sync_state_t s;

	always_comb
	begin
		s = r;
		s.stage1 = pinIn;
		// first stage feeds only the second stage
		s.stage2 = r.stage1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			r <= '1;
		else if (ce)
			r <= s;
	end

	assign pinSync = r.stage2;
endmodule : usr_sync

// file: core/usr_fifo.sv
// two-entry receive buffer holding each character with its status bits
`timescale 1ns/10ps
module usr_fifo (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic flush,
	input wire logic wrValid,
	input wire usr_pkg::usr_entry_t wrData,
	output logic wrReady,
	input wire logic rdPop,
	output logic rdValid,
	output usr_pkg::usr_entry_t rdData
);
	usr_pkg::usr_fifo_state_t r;
	usr_pkg::usr_fifo_state_t s;
	logic doWr;
	logic doRd;

	assign wrReady = (r.count != 2'h2);
	assign rdValid = (r.count != 2'h0);
	assign rdData = r.mem[r.rdPtr];
	assign doWr = wrValid && wrReady;
	assign doRd = rdPop && rdValid;

	always_comb
	begin
		s = r;
		if (flush)
		begin
			s.count = 2'h0;
			s.rdPtr = 1'b0;
			s.wrPtr = 1'b0;
		end
		else
		begin
			if (doWr)
			begin
				s.mem[r.wrPtr] = wrData;
				s.wrPtr = ~r.wrPtr;
			end
			if (doRd)
				s.rdPtr = ~r.rdPtr;
			if (doWr && !doRd)
				s.count = r.count + 2'h1;
			else if (doRd && !doWr)
				s.count = r.count - 2'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			r <= '0;
		else if (ce)
			r <= s;
	end
endmodule : usr_fifo

// file: core/usr_rx.sv
// serial receiver: bit recovery, frame assembly, receive buffer and register port
`timescale 1ns/10ps
`include "usr_defines.svh"

// Behaviour
// - receiver_enable set hands the serial input pin to the receiver
// - synchronous mode samples bits on the external transfer clock pin
// - bits after a valid start are shifted in up to first stop; second ignored
// - after the first stop bit the frame moves into the receive buffer
// - five to seven bit characters read with zero upper data bits
// - nine-bit mode keeps ninth bit and error flags per entry; data read advances
// - receive-complete flag high exactly while the buffer holds unread data
// - clearing enable stops reception at once and drops the frame in progress
// - disabling empties the receive buffer so receive-complete reads zero
// - interrupt requested while its enable, global enable and receive-complete are set
// - error flags travel with their frame; software writes cannot change them
// - error flags never raise an interrupt
// - frame error is the inverted first stop bit, whatever the stop bit setting
// - overrun when buffer full, a frame waits, and a new start is detected
// - overrun flag clears with the next successful transfer into the buffer
// - parity error only with checking enabled at arrival and a mismatch
// - checker compares data parity with received parity bit in selected sense
// - asynchronous start bit judged by majority of samples 8,9,10 or 4,5,6
// - each asynchronous bit decided by majority of three centre samples, 16 or 8 per bit
module usr_rx (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic serialIn,
	input wire logic syncClkIn,
	input wire logic globalIrqEn,
	output logic rxPinOverride,
	output logic rxComplete,
	output logic rxIrq
);
	usr_pkg::usr_rx_state_t r;
	usr_pkg::usr_rx_state_t s;

	logic [1:0] pinSync;
	logic rxS;
	logic xckS;
	logic fifoReady;
	logic fifoValid;
	usr_pkg::usr_entry_t head;
	usr_pkg::usr_entry_t wrEntry;
	logic pop;

	logic tick;
	logic xckRise;
	logic [4:0] spb;
	logic [4:0] voteFirst;
	logic [4:0] voteLast;
	logic [4:0] cntN;
	logic [2:0] voteN;
	logic decide;
	logic bitVal;
	logic startSeen;
	logic [3:0] nbits;
	logic [7:0] dataMask;

	usr_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.pinIn({syncClkIn, serialIn}),
		.pinSync(pinSync)
	);

	assign rxS = pinSync[0];
	assign xckS = pinSync[1];

	// the waiting frame picks up the overrun mark only at the moment it enters the buffer
	always_comb
	begin
		wrEntry = r.pendEntry;
		wrEntry[`USR_E_DOR] = r.lost;
	end

	usr_fifo u_fifo (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.flush(!r.receiver_enable),
		.wrValid(r.pend),
		.wrData(wrEntry),
		.wrReady(fifoReady),
		.rdPop(pop),
		.rdValid(fifoValid),
		.rdData(head)
	);

	assign pop = rd && (addr == `USR_ADDR_DATA) && fifoValid;
	assign rxComplete = fifoValid;
	// error flags deliberately left out of the request term
	assign rxIrq = r.rx_done_irq_enable && globalIrqEn && fifoValid;
	assign rxPinOverride = r.receiver_enable;
	assign rdata = r.rdata;

	assign tick = (r.baudCnt == 8'h00);
	assign xckRise = xckS && !r.xckPrev;
	assign spb = r.u2x ? `USR_SPB_DOUBLE : `USR_SPB_NORMAL;
	assign voteFirst = r.u2x ? `USR_VOTE_DOUBLE : `USR_VOTE_NORMAL;
	assign voteLast = voteFirst + `USR_VOTE_SPAN;
	assign cntN = (r.cnt >= spb) ? 5'h01 : r.cnt + 5'h01;
	assign nbits = r.ucsz2 ? `USR_NINE_BITS : `USR_MIN_BITS + {2'h0, r.char_size_field};
	// reserved sizes with ucsz2 set are received as nine bits, all eight data bits read
	assign dataMask = r.ucsz2 ? 8'hFF : (8'hFF >> (2'h3 - r.char_size_field));

	always_comb
	begin
		voteN = r.vote;
		if (cntN >= voteFirst && cntN <= voteLast)
			voteN = {r.vote[1:0], rxS};
	end

	always_comb
	begin
		if (r.syncMode)
		begin
			decide = xckRise && (r.st != usr_pkg::RX_IDLE);
			bitVal = rxS;
			startSeen = xckRise && (r.st == usr_pkg::RX_IDLE) && !rxS;
		end
		else
		begin
			decide = tick && (r.st != usr_pkg::RX_IDLE) && (cntN == voteLast);
			bitVal = (voteN[0] & voteN[1]) | (voteN[0] & voteN[2]) | (voteN[1] & voteN[2]);
			startSeen = tick && (r.st == usr_pkg::RX_IDLE) && !rxS && r.rxPrev;
		end
	end

	always_comb
	begin
		s = r;
		s.xckPrev = xckS;
		// a line held low after a bad stop bit must rise before a new start counts
		if (tick)
			s.rxPrev = rxS;
		s.baudCnt = tick ? r.baud : r.baudCnt - 8'h01;

		if (r.pend && fifoReady)
		begin
			s.pend = 1'b0;
			s.lost = 1'b0;
		end

		if (!r.syncMode && tick && r.st != usr_pkg::RX_IDLE)
		begin
			s.cnt = cntN;
			s.vote = voteN;
		end

		if (startSeen)
		begin
			s.cnt = 5'h01;
			s.vote = 3'h0;
			s.st = r.syncMode ? usr_pkg::RX_DATA : usr_pkg::RX_START;
			s.bitIdx = 4'h0;
			s.shift = 9'h000;
			s.parErr = 1'b0;
			s.parEn = r.parEnable;
			if (r.syncMode && r.pend && !fifoReady)
			begin
				s.pend = 1'b0;
				s.lost = 1'b1;
			end
		end

		if (decide)
		begin
			case (r.st)
				usr_pkg::RX_START:
				begin
					if (bitVal)
						s.st = usr_pkg::RX_IDLE;
					else
					begin
						s.st = usr_pkg::RX_DATA;
						// a full buffer plus a waiting frame loses the waiting frame
						if (r.pend && !fifoReady)
						begin
							s.pend = 1'b0;
							s.lost = 1'b1;
						end
					end
				end
				usr_pkg::RX_DATA:
				begin
					s.shift[r.bitIdx] = bitVal;
					s.bitIdx = r.bitIdx + 4'h1;
					if (r.bitIdx == nbits - 4'h1)
						s.st = r.parEn ? usr_pkg::RX_PARITY : usr_pkg::RX_STOP;
				end
				usr_pkg::RX_PARITY:
				begin
					// even: data plus parity bit must xor to zero; odd flips the sense
					s.parErr = (^r.shift) ^ bitVal ^ r.parOdd;
					s.st = usr_pkg::RX_STOP;
				end
				usr_pkg::RX_STOP:
				begin
					// only the first stop bit is looked at; the line is idle again here
					s.st = usr_pkg::RX_IDLE;
					s.pend = 1'b1;
					s.pendEntry[7:0] = r.shift[7:0];
					s.pendEntry[`USR_E_NINTH] = r.shift[8];
					s.pendEntry[`USR_E_FE] = !bitVal;
					s.pendEntry[`USR_E_PE] = r.parEn && r.parErr;
					s.pendEntry[`USR_E_DOR] = 1'b0;
				end
				default:
					s.st = usr_pkg::RX_IDLE;
			endcase
		end

		if (wr)
		begin
			if (addr == `USR_ADDR_STAT_A)
				s.u2x = wdata[`USR_A_U2X];
			else if (addr == `USR_ADDR_CTRL_B)
			begin
				s.rx_done_irq_enable = wdata[`USR_B_RX_DONE_IRQ_ENABLE];
				s.receiver_enable = wdata[`USR_B_RECEIVER_ENABLE];
				s.ucsz2 = wdata[`USR_B_UCSZ2];
			end
			else if (addr == `USR_ADDR_CTRL_C)
			begin
				s.syncMode = wdata[`USR_C_SYNC];
				s.parEnable = wdata[`USR_C_PAR_EN];
				s.parOdd = wdata[`USR_C_PAR_ODD];
				s.stop2 = wdata[`USR_C_STOP2];
				s.char_size_field = wdata[`USR_C_CHAR_SIZE_FIELD_LO +: 2];
			end
			else if (addr == `USR_ADDR_BAUD)
				s.baud = wdata;
		end

		// disable wins over any frame event in the same cycle
		if (!r.receiver_enable)
		begin
			s.st = usr_pkg::RX_IDLE;
			s.pend = 1'b0;
			s.lost = 1'b0;
		end

		s.rdata = 8'h00;
		if (rd)
		begin
			if (addr == `USR_ADDR_DATA)
				s.rdata = fifoValid ? (head[7:0] & dataMask) : 8'h00;
			else if (addr == `USR_ADDR_STAT_A)
			begin
				s.rdata[`USR_A_RXC] = fifoValid;
				s.rdata[`USR_A_FE] = fifoValid && head[`USR_E_FE];
				s.rdata[`USR_A_DOR] = fifoValid && head[`USR_E_DOR];
				s.rdata[`USR_A_PE] = fifoValid && head[`USR_E_PE];
				s.rdata[`USR_A_U2X] = r.u2x;
			end
			else if (addr == `USR_ADDR_CTRL_B)
			begin
				s.rdata[`USR_B_RX_DONE_IRQ_ENABLE] = r.rx_done_irq_enable;
				s.rdata[`USR_B_RECEIVER_ENABLE] = r.receiver_enable;
				s.rdata[`USR_B_UCSZ2] = r.ucsz2;
				s.rdata[`USR_B_NINTH_BIT_RECEIVED] = fifoValid && head[`USR_E_NINTH];
			end
			else if (addr == `USR_ADDR_CTRL_C)
			begin
				s.rdata[`USR_C_SYNC] = r.syncMode;
				s.rdata[`USR_C_PAR_EN] = r.parEnable;
				s.rdata[`USR_C_PAR_ODD] = r.parOdd;
				s.rdata[`USR_C_STOP2] = r.stop2;
				s.rdata[`USR_C_CHAR_SIZE_FIELD_LO +: 2] = r.char_size_field;
			end
			else if (addr == `USR_ADDR_BAUD)
				s.rdata = r.baud;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			r <= '0;
			r.st <= usr_pkg::RX_IDLE;
			r.baud <= `USR_RST_BAUD;
			r.char_size_field <= `USR_RST_CHAR_SIZE_FIELD;
			r.xckPrev <= 1'b1;
			r.rxPrev <= 1'b1;
		end
		else if (ce)
			r <= s;
	end
endmodule : usr_rx

// file: dv/usr_rx_asserts.sv
// port-level assertions for the serial receiver
`timescale 1ns/10ps
module usr_rx_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic serialIn,
	input wire logic syncClkIn,
	input wire logic globalIrqEn,
	input wire logic rxPinOverride,
	input wire logic rxComplete,
	input wire logic rxIrq
);
	logic pop_r, rdAny_r, rdStat_r;
	always_ff @(posedge clk)
	begin
		pop_r <= rd && addr == 3'h0;
		rdAny_r <= rd;
		rdStat_r <= rd && addr == 3'h1;
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence enWrite;
		wr && addr == 3'h2 && wdata[4];
	endsequence
	sequence offWrite;
		wr && addr == 3'h2 && !wdata[4];
	endsequence
	a_enable_takes_pin: assert property (enWrite |=> rxPinOverride)
		else $error("pin not taken");
	a_disable_frees_pin: assert property (offWrite |=> !rxPinOverride)
		else $error("pin not freed");
	a_disable_flushes: assert property (offWrite |-> ##[1:3] !rxComplete)
		else $error("no flush on disable");
	a_irq_needs_rxc: assert property (rxIrq |-> rxComplete && globalIrqEn)
		else $error("stray interrupt");
	a_rxc_holds: assert property (rxComplete && rxPinOverride && !wr && !rd |=> rxComplete)
		else $error("flag dropped");
	a_rxc_fall_cause: assert property ($fell(rxComplete) |-> pop_r || !rxPinOverride)
		else $error("flag fell unread");
	a_rdata_after_rd: assert property (rdata != 8'h00 |-> rdAny_r)
		else $error("data outside read");
	a_status_rxc: assert property (rdStat_r |-> rdata[7] == $past(rxComplete))
		else $error("status flag wrong");
endmodule : usr_rx_asserts

// file: dv/usr_line_model.sv
// remote serial transmitter driving the receive line and transfer clock
`timescale 1ns/10ps
module usr_line_model (
	output logic serialIn,
	output logic syncClkIn
);
	// line idles high; the transfer clock only runs inside a frame
	initial
	begin
		serialIn = 1'b1;
		syncClkIn = 1'b0;
	end
	// start bit in f[0], lsb first; data moves on the falling clock edge
	task automatic send(input logic [11:0] f, input int n, input bit sy, input int hb);
		for (int i = 0; i < n; i++)
		begin
			serialIn <= f[i];
			#hb syncClkIn <= sy;
			#hb syncClkIn <= 1'b0;
		end
		// a low stop bit is released here; a high one already leaves the line idle
		if (!f[n-1])
			serialIn <= 1'b1;
	endtask : send
	task glitch();
		serialIn <= 1'b0;
		#80 serialIn <= 1'b1;
	endtask : glitch
endmodule : usr_line_model

// file: dv/tb_usr_rx.sv
// self-checking bench for the serial receiver
`timescale 1ns/10ps
module tb_usr_rx;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0;
	logic globalIrqEn = 1'b1;
	logic [7:0] rdata, v;
	logic serialIn, syncClkIn, rxPinOverride, rxComplete, rxIrq;
	int bad_count = 0, compares = 0, cycles = 0;
	always #20 clk = ~clk;
	usr_rx usr_rx_i (.clk(clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .serialIn(serialIn), .syncClkIn(syncClkIn),
		.globalIrqEn(globalIrqEn), .rxPinOverride(rxPinOverride), .rxComplete(rxComplete),
		.rxIrq(rxIrq));
	usr_line_model usr_line_model_i (.serialIn(serialIn), .syncClkIn(syncClkIn));
	task tally_and_finish();
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// the full run needs a few thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	task chk(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task tx(input logic [11:0] f, input int n);
		usr_line_model_i.send(f, n, 1'b0, 160);
	endtask : tx
	task wrx();
		for (int n = 0; n < 300 && rxComplete !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk(rxIrq, 1'b1);
	endtask : wrx
	// status before data: the data read advances the buffer
	task rx(input logic [7:0] st, input logic [7:0] dat);
		wrx();
		rreg(3'h1, v);
		chk(v, st);
		rreg(3'h0, v);
		chk(v, dat);
	endtask : rx
	task t_basic();
		rreg(3'h3, v);
		chk(v, 8'h06);
		wreg(3'h6, 8'hFF);
		rreg(3'h6, v);
		chk(v, 8'h00);
		tx({1'b1, 8'hA5, 1'b0}, 10);
		rx(8'h82, 8'hA5);
		chk(rxComplete, 1'b0);
		tx({1'b0, 8'h3C, 1'b0}, 10);
		rx(8'h92, 8'h3C);
		usr_line_model_i.glitch();
		repeat (30) @(posedge clk);
		chk(rxComplete, 1'b0);
	endtask : t_basic
	// sixteen samples per bit: bits twice as long as in the double speed frames
	task t_normal();
		wreg(3'h1, 8'h00);
		usr_line_model_i.send({1'b1, 8'h96, 1'b0}, 10, 1'b0, 320);
		rx(8'h80, 8'h96);
		wreg(3'h1, 8'h02);
	endtask : t_normal
	task t_overrun();
		for (int i = 1; i < 5; i++)
			tx({1'b1, 8'(8'h11 * i), 1'b0}, 10);
		wreg(3'h1, 8'h1E);
		rx(8'h82, 8'h11);
		rx(8'h82, 8'h22);
		rx(8'h8A, 8'h44);
		tx({1'b1, 8'h55, 1'b0}, 10);
		rx(8'h82, 8'h55);
	endtask : t_overrun
	task t_parity();
		logic p;
		for (int o = 0; o < 2; o++)
		begin
			wreg(3'h3, 8'h26 | 8'(o << 4));
			for (int e = 0; e < 2; e++)
			begin
				p = ^8'h5B ^ o[0] ^ e[0];
				tx({1'b1, p, 8'h5B, 1'b0}, 11);
				rx(8'h82 | 8'(e << 2), 8'h5B);
			end
		end
	endtask : t_parity
	task t_sizes();
		wreg(3'h3, 8'h00);
		tx({1'b1, 5'h1F, 1'b0}, 7);
		rx(8'h82, 8'h1F);
		wreg(3'h3, 8'h06);
		wreg(3'h2, 8'h94);
		tx({1'b1, 9'h1A5, 1'b0}, 11);
		tx({1'b1, 9'h05A, 1'b0}, 11);
		wrx();
		rreg(3'h2, v);
		chk(v, 8'h96);
		rx(8'h82, 8'hA5);
		rreg(3'h2, v);
		chk(v, 8'h94);
		rx(8'h82, 8'h5A);
		wreg(3'h2, 8'h90);
	endtask : t_sizes
	// a wrong divisor would garble the frame if the internal rate were used
	task t_sync();
		wreg(3'h4, 8'h07);
		wreg(3'h3, 8'h46);
		usr_line_model_i.send({1'b1, 8'hC3, 1'b0}, 10, 1'b1, 160);
		rx(8'h82, 8'hC3);
		wreg(3'h3, 8'h06);
		wreg(3'h4, 8'h00);
	endtask : t_sync
	task t_disable();
		tx({1'b1, 8'h77, 1'b0}, 10);
		wrx();
		@(posedge clk);
		globalIrqEn <= 1'b0;
		@(posedge clk);
		#1 chk(rxIrq, 1'b0);
		@(posedge clk);
		globalIrqEn <= 1'b1;
		wreg(3'h2, 8'h80);
		repeat (3) @(posedge clk);
		chk(rxComplete, 1'b0);
		chk(rxPinOverride, 1'b0);
		rreg(3'h0, v);
		chk(v, 8'h00);
		wreg(3'h2, 8'h90);
		// upper data bits high: a receiver that kept going would still finish this frame
		fork
			tx({1'b1, 8'hF7, 1'b0}, 10);
			begin
				#1610 wreg(3'h2, 8'h80);
				wreg(3'h2, 8'h90);
			end
		join
		repeat (20) @(posedge clk);
		chk(rxComplete, 1'b0);
	endtask : t_disable
	task t_flush();
		int k;
		tx({1'b1, 8'h12, 1'b0}, 10);
		tx({1'b1, 8'h34, 1'b0}, 10);
		wrx();
		repeat (4) @(posedge clk);
		k = 0;
		while (rxComplete === 1'b1 && k < 4)
		begin
			rreg(3'h0, v);
			k++;
		end
		chk(9'(k), 9'h002);
		chk(rxComplete, 1'b0);
	endtask : t_flush
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		wreg(3'h1, 8'h02);
		wreg(3'h2, 8'h90);
		t_basic();
		t_normal();
		t_overrun();
		t_parity();
		t_sizes();
		t_sync();
		t_disable();
		t_flush();
		tally_and_finish();
	end
endmodule : tb_usr_rx
bind usr_rx usr_rx_asserts usr_rx_asserts_i (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serialIn(serialIn),
	.syncClkIn(syncClkIn), .globalIrqEn(globalIrqEn), .rxPinOverride(rxPinOverride),
	.rxComplete(rxComplete), .rxIrq(rxIrq));
